/* smc_pkg.sv */
package smc_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  // Device register map
  localparam logic [3:0]  MAIN_CONTROL_IDX      = 4'h0;
  localparam logic [3:0]  FRACTION_UPPER_IDX    = 4'h1;
  localparam logic [15:0] MAIN_CONTROL_RESET    = 16'h0003;
  localparam logic [15:0] FRACTION_UPPER_RESET  = 16'h0000;
  // Main control field positions
  localparam int unsigned SOFT_RESET_BIT            = 13;
  localparam int unsigned POWER_OFF_REQUEST_BIT     = 12;
  localparam int unsigned TX_RX_SWITCH_SOURCE_BIT   = 11;
  localparam int unsigned TX_RX_PIN_POLARITY_BIT    = 10;
  localparam int unsigned PROFILE_RECAL_TRIGGER_BIT = 9;
  localparam int unsigned PROFILE_SWITCH_SOURCE_BIT = 8;
  localparam int unsigned DUAL_PROFILE_CAL_BIT      = 7;
  localparam int unsigned PROFILE_SELECT_BIT        = 6;
  localparam int unsigned CALIBRATION_ENABLE_BIT    = 0;
  // Fixed pattern the host forces on every main control write
  localparam logic [15:0] MAIN_CONTROL_FIXED_MASK   = 16'hc03e;
  localparam logic [15:0] MAIN_CONTROL_FIXED_VALUE  = 16'h0002;
  // Host APB register offsets (byte addresses)
  localparam logic [7:0]  HOST_CMD_OFFSET    = 8'h00;
  localparam logic [7:0]  HOST_STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  HOST_RDATA_OFFSET  = 8'h08;
  localparam logic [31:0] HOST_CMD_RESET     = 32'h0000_0000;
  // Power-up settle time before recalibration write
  localparam int unsigned CLK_MHZ           = 40;
  localparam int unsigned RECAL_WAIT_US     = 100;
  localparam int unsigned RECAL_WAIT_CYCLES = RECAL_WAIT_US * CLK_MHZ;
endpackage : smc_pkg

/* smc_if.sv */
`timescale 1ns/100ps
interface smc_if;
  logic        wr_en;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport device (
    input  wr_en,
    input  addr,
    input  wdata,
    output rdata
  );
  modport host (
    output wr_en,
    output addr,
    output wdata,
    input  rdata
  );
endinterface : smc_if

/* smc_device.sv */
`timescale 1ns/100ps
module smc_device (
  input  wire logic  pclk,
  input  wire logic  presetn,
  smc_if.device      bus,
  input  wire logic  tx_rx_control_pin,
  output logic       powered_down,
  output logic       tx_select,
  output logic       profile_b_active,
  output logic       cal_start,
  output logic       dual_cal_start,
  output logic       profile_recal_start,
  output logic [7:0] fraction_denominator_a_hi,
  output logic [7:0] fraction_numerator_a_hi
);
  logic [15:0] main_control_ff;
  logic [15:0] fraction_upper_ff;
  logic        pin_sync1_ff;
  logic        pin_sync2_ff;
  logic        recal_prev_ff;
  logic        main_wr;
  logic        upper_wr;
  logic        soft_reset;
  logic        pin_tx;
  logic        nxt_tx;
  logic        nxt_profile_b;

  assign main_wr    = bus.wr_en && (bus.addr == smc_pkg::MAIN_CONTROL_IDX);
  assign upper_wr   = bus.wr_en && (bus.addr == smc_pkg::FRACTION_UPPER_IDX);
  assign soft_reset = main_wr && bus.wdata[smc_pkg::SOFT_RESET_BIT];

  // soft reset restores defaults, bit never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_control_ff <= smc_pkg::MAIN_CONTROL_RESET;
    end else if (soft_reset) begin
      main_control_ff <= smc_pkg::MAIN_CONTROL_RESET;
    end else if (main_wr) begin
      main_control_ff <= bus.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fraction_upper_ff <= smc_pkg::FRACTION_UPPER_RESET;
    end else if (soft_reset) begin
      fraction_upper_ff <= smc_pkg::FRACTION_UPPER_RESET;
    end else if (upper_wr) begin
      fraction_upper_ff <= bus.wdata;
    end
  end

  // Pin comes from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_ff <= 1'b0;
      pin_sync2_ff <= 1'b0;
    end else begin
      pin_sync1_ff <= tx_rx_control_pin;
      pin_sync2_ff <= pin_sync1_ff;
    end
  end

  // polarity maps pin level to transmit
  assign pin_tx = main_control_ff[smc_pkg::TX_RX_PIN_POLARITY_BIT] ? pin_sync2_ff
                                                                   : !pin_sync2_ff;

  always_comb begin
    // tx/rx source; pin ignored when register-controlled
    nxt_tx = main_control_ff[smc_pkg::TX_RX_SWITCH_SOURCE_BIT] ? pin_tx : tx_select;
    nxt_profile_b = main_control_ff[smc_pkg::PROFILE_SELECT_BIT];
    // pin switching only with dual calibration enabled
    if (main_control_ff[smc_pkg::PROFILE_SWITCH_SOURCE_BIT] &&
        main_control_ff[smc_pkg::DUAL_PROFILE_CAL_BIT]) begin
      nxt_profile_b = pin_tx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_down     <= 1'b0;
      tx_select        <= 1'b0;
      profile_b_active <= 1'b0;
    end else begin
      powered_down     <= main_control_ff[smc_pkg::POWER_OFF_REQUEST_BIT];
      tx_select        <= nxt_tx;
      profile_b_active <= nxt_profile_b;
    end
  end

  // Calibration pulses: starts one cycle after the triggering write, recalibration two cycles after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_start           <= 1'b0;
      dual_cal_start      <= 1'b0;
      profile_recal_start <= 1'b0;
      recal_prev_ff       <= 1'b0;
    end else begin
      // calibrate on main write with bit 0 set, except a soft reset write
      cal_start      <= main_wr && !soft_reset &&
                        bus.wdata[smc_pkg::CALIBRATION_ENABLE_BIT];
      // dual calibration rides on the calibration start
      dual_cal_start <= main_wr && !soft_reset &&
                        bus.wdata[smc_pkg::CALIBRATION_ENABLE_BIT] &&
                        bus.wdata[smc_pkg::DUAL_PROFILE_CAL_BIT];
      // rising trigger bit recalibrates both profiles
      recal_prev_ff       <= main_control_ff[smc_pkg::PROFILE_RECAL_TRIGGER_BIT];
      profile_recal_start <= main_control_ff[smc_pkg::PROFILE_RECAL_TRIGGER_BIT] &&
                             !recal_prev_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fraction_denominator_a_hi <= 8'h00;
      fraction_numerator_a_hi   <= 8'h00;
    end else begin
      fraction_denominator_a_hi <= fraction_upper_ff[15:8];
      fraction_numerator_a_hi   <= fraction_upper_ff[7:0];
    end
  end

  // Readback is combinational so the host sees it in its access cycle
  assign bus.rdata = (bus.addr == smc_pkg::MAIN_CONTROL_IDX)   ? main_control_ff :
                     (bus.addr == smc_pkg::FRACTION_UPPER_IDX) ? fraction_upper_ff :
                                                                 16'h0000;
endmodule : smc_device

/* smc_host.sv */
`timescale 1ns/100ps
module smc_host #(
  parameter int unsigned RECAL_WAIT = smc_pkg::RECAL_WAIT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  smc_if.host              dev
);
  if (RECAL_WAIT < 1) begin : g_bad_wait
    $error("RECAL_WAIT must be at least 1");
  end

  typedef enum logic [2:0] {
    SMC_IDLE  = 3'b001,
    SMC_WRITE = 3'b010,
    SMC_WAIT  = 3'b100
  } smc_state_e;

  smc_state_e  state_ff;
  logic [31:0] cmd_ff;
  logic [31:0] wait_cnt_ff;
  logic        access;
  logic        cmd_wr;
  logic        leaving_pd;
  logic [15:0] fixed_data;

  assign access = psel && penable;
  // Command: [19:16] address, [15:0] data; write while idle starts a transfer
  assign cmd_wr = access && pwrite && (paddr == smc_pkg::HOST_CMD_OFFSET) &&
                  (state_ff == SMC_IDLE);
  // force fixed bits on main control writes
  assign fixed_data = (cmd_ff[19:16] == smc_pkg::MAIN_CONTROL_IDX) ?
                      ((cmd_ff[15:0] & ~smc_pkg::MAIN_CONTROL_FIXED_MASK) |
                       smc_pkg::MAIN_CONTROL_FIXED_VALUE) : cmd_ff[15:0];
  // power bit falling needs a recalibration write
  assign leaving_pd = (cmd_ff[19:16] == smc_pkg::MAIN_CONTROL_IDX) &&
                      dev.rdata[smc_pkg::POWER_OFF_REQUEST_BIT] &&
                      !fixed_data[smc_pkg::POWER_OFF_REQUEST_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= smc_pkg::HOST_CMD_RESET;
    end else if (cmd_wr) begin
      cmd_ff <= pwdata;
    end else if (state_ff == SMC_WRITE && leaving_pd) begin
      // trigger not left set in the follow-up write
      cmd_ff[smc_pkg::PROFILE_RECAL_TRIGGER_BIT] <= 1'b0;
      cmd_ff[smc_pkg::CALIBRATION_ENABLE_BIT]    <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= SMC_IDLE;
      wait_cnt_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        SMC_IDLE: begin
          if (cmd_wr) begin
            state_ff <= SMC_WRITE;
          end
        end
        SMC_WRITE: begin
          if (leaving_pd) begin
            state_ff    <= SMC_WAIT;
            wait_cnt_ff <= RECAL_WAIT;
          end else begin
            state_ff <= SMC_IDLE;
          end
        end
        SMC_WAIT: begin
          if (wait_cnt_ff == 32'h0000_0001) begin
            state_ff <= SMC_WRITE;
          end
          wait_cnt_ff <= wait_cnt_ff - 32'h0000_0001;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev.wr_en <= 1'b0;
      dev.addr  <= 4'h0;
      dev.wdata <= 16'h0000;
    end else begin
      dev.wr_en <= (state_ff == SMC_WRITE);
      // Track the command's register so readback and power-down check agree
      dev.addr  <= cmd_wr ? pwdata[19:16] : cmd_ff[19:16];
      dev.wdata <= fixed_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      unique case (paddr)
        smc_pkg::HOST_CMD_OFFSET:    prdata <= cmd_ff;
        smc_pkg::HOST_STATUS_OFFSET: prdata <= {29'h0, state_ff};
        smc_pkg::HOST_RDATA_OFFSET:  prdata <= {16'h0000, dev.rdata};
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= psel && !penable;
        end
      endcase
    end
  end
endmodule : smc_host

/* smc_props.sv */
`timescale 1ns/100ps
module smc_props (
  input logic        pclk,
  input logic        presetn,
  input logic        wr_en,
  input logic [3:0]  addr,
  input logic [15:0] wdata,
  input logic [15:0] rdata,
  input logic        powered_down,
  input logic        cal_start,
  input logic        dual_cal_start,
  input logic        profile_recal_start,
  input logic        profile_b_active,
  input logic        tx_select,
  input logic [7:0]  fraction_denominator_a_hi,
  input logic [7:0]  fraction_numerator_a_hi
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_main_wr;
    wr_en && addr == 4'h0 && !wdata[13];
  endsequence
  // Captures the written value; the level shows two edges later
  property p_lvl(c, s, o);
    logic [15:0] v;
    (c, v = s) |-> ##2 o == v;
  endproperty
  a_reset_value: assert property ($rose(presetn) && addr == 4'h0 |-> rdata == 16'h0003)
    else $error("main control reset value wrong");
  a_fixed_bits: assert property (wr_en && addr == 4'h0 |-> (wdata & 16'hc03e) == 16'h0002)
    else $error("fixed bits not forced");
  a_soft_reset: assert property (wr_en && addr == 4'h0 && wdata[13] |=> !cal_start [*2])
    else $error("soft reset started calibration");
  a_cal_start: assert property (s_main_wr and wdata[0] |-> ##[1:2] cal_start)
    else $error("calibration not started");
  a_cal_quiet: assert property (wr_en && addr == 4'h0 && !wdata[0] |=> !cal_start [*2])
    else $error("calibration started with bit clear");
  a_dual_cal: assert property (s_main_wr and wdata[0] && wdata[7] |=> dual_cal_start)
    else $error("dual calibration not started");
  a_power_level: assert property (p_lvl(wr_en && addr == 4'h0 && !wdata[13], wdata[12],
    powered_down))
    else $error("power down level wrong");
  a_profile_sel: assert property (p_lvl(wr_en && addr == 4'h0 && !wdata[13] && !wdata[8],
    wdata[6], profile_b_active))
    else $error("profile select wrong");
  a_fraction_bytes: assert property (p_lvl(wr_en && addr == 4'h1, wdata,
    {fraction_denominator_a_hi, fraction_numerator_a_hi}))
    else $error("fraction bytes wrong");
  a_recal_rise: assert property (s_main_wr and wdata[9] && !rdata[9]
    |-> ##[1:2] profile_recal_start)
    else $error("recalibration not triggered");
  a_pin_ignored: assert property ((addr == 4'h0 && !rdata[11] && !rdata[8] && !wr_en) [*4]
    |-> $stable(tx_select) && $stable(profile_b_active))
    else $error("pin moved outputs in register mode");
endmodule : smc_props

/* smc_bench.sv */
`timescale 1ns/100ps
module smc_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        tx_rx_control_pin = 1'b0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, e, powered_down, tx_select, profile_b_active, cal_start;
  logic        profile_recal_start, dual_cal_start;
  logic [7:0]  den_hi, num_hi;
  logic [15:0] v;
  int          n_fail = 0, comparisons = 0, cyc = 0, mc = 3, fr = 0;
  smc_if bus_inst ();
  smc_device smc_device_inst (.pclk, .presetn, .bus(bus_inst), .tx_rx_control_pin,
    .powered_down, .tx_select, .profile_b_active, .cal_start, .dual_cal_start,
    .profile_recal_start, .fraction_denominator_a_hi(den_hi), .fraction_numerator_a_hi(num_hi));
  smc_host #(.RECAL_WAIT(5)) smc_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dev(bus_inst));
  smc_props smc_props_inst (.pclk, .presetn, .wr_en(bus_inst.wr_en), .addr(bus_inst.addr),
    .wdata(bus_inst.wdata), .rdata(bus_inst.rdata), .powered_down, .cal_start, .dual_cal_start,
    .profile_recal_start, .profile_b_active, .tx_select, .fraction_denominator_a_hi(den_hi),
    .fraction_numerator_a_hi(num_hi));
  always #12.5 pclk = ~pclk;
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Issues a device write, polls until idle, updates the model
  task cmd(input logic [3:0] a, input logic [15:0] d);
    int o;
    o = mc;
    apb(1'b1, 8'h00, {12'h0, a, d});
    apb(1'b0, 8'h04, 32'h0);
    while (r !== 32'h1) apb(1'b0, 8'h04, 32'h0);
    if (a == 4'h0 && d[13]) begin
      mc = 3;
      fr = 0;
    end else if (a == 4'h0) begin
      mc = (d & 'h3fc1) | 2;
      if (o[12] && !d[12]) mc = (mc | 1) & ~'h200;
    end else if (a == 4'h1) fr = d;
    // Outputs launch at the edge the poll ends; look one edge later
    @(posedge pclk);
  endtask : cmd
  task rd(input int exp);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, exp);
  endtask : rd
  initial begin
    void'($urandom(85659));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cmd(4'h1, 16'($urandom));
    rd(fr);
    chk({den_hi, num_hi}, fr);
    $display("fraction test done");
    repeat (8) begin
      v = 16'($urandom) & 16'hc6ff;
      cmd(4'h0, v);
      rd(mc);
      chk(profile_b_active, mc[6]);
    end
    $display("random control test done");
    cmd(4'h0, 16'h1000);
    chk(powered_down, 1'b1);
    cmd(4'h0, 16'h0200);
    rd(mc);
    chk(powered_down, 1'b0);
    $display("power down test done");
    cmd(4'h1, 16'habcd);
    cmd(4'h0, 16'h2000);
    rd(mc);
    chk({den_hi, num_hi}, 16'h0);
    $display("soft reset test done");
    for (int i = 0; i < 4; i++) begin
      cmd(4'h0, 16'h0980 | (i[0] ? 16'h0400 : 16'h0000));
      tx_rx_control_pin <= i[1];
      repeat (6) @(posedge pclk);
      chk(tx_select, i[0] ? i[1] : !i[1]);
      chk(profile_b_active, i[0] ? i[1] : !i[1]);
    end
    // register switch source and dual calibration off, no pin switching
    cmd(4'h0, 16'h0040);
    repeat (2) begin
      tx_rx_control_pin <= ~tx_rx_control_pin;
      repeat (6) @(posedge pclk);
      chk(profile_b_active, 1'b1);
      chk(tx_select, 1'b1);
    end
    $display("pin test done");
    apb(1'b0, 8'h0c, 32'h0);
    chk(e, 1'b1);
    $display("unmapped test done");
    end_of_test();
  end
endmodule : smc_bench
